/* File: src/cgd_pkg.sv */
// shared constants and carrier types for the gateway configuration command decoder
package cgd_pkg;
  // opcodes arriving from the wireless serial link
  localparam logic [7:0] CGD_OP_IFACE = 8'h04;
  localparam logic [7:0] CGD_OP_RATE = 8'h05;
  localparam logic [7:0] CGD_OP_ECHO = 8'h06;
  localparam logic [7:0] CGD_OP_SH_ADD = 8'h07;
  localparam logic [7:0] CGD_OP_GET_FILT = 8'h09;
  localparam logic [7:0] CGD_OP_GET_RATE = 8'h0B;
  // parameter byte counts
  localparam logic [3:0] CGD_LEN_ONE = 4'h1;
  localparam logic [3:0] CGD_LEN_SH = 4'h8;
  // bit-rate selector range and reset value (2 = 125k)
  localparam logic [2:0] CGD_RATE_MAX = 3'h5;
  localparam logic [2:0] CGD_RATE_RST = 3'h2;
  localparam logic [7:0] CGD_ECHO_ON = 8'h01;
  // special-handling option flag bits
  localparam int CGD_FLAG_TP_BIT = 0;
  localparam int CGD_FLAG_TAG_BIT = 1;
  // table sizes
  localparam int CGD_NFILT = 4;
  localparam int CGD_NSH = 4;
  localparam logic [2:0] CGD_NFILT_MAX = 3'h4;
  localparam logic [2:0] CGD_NSH_MAX = 3'h4;
  // apb register byte offsets
  localparam logic [7:0] CGD_A_CTRL = 8'h00;
  localparam logic [7:0] CGD_A_STATUS = 8'h04;
  localparam logic [7:0] CGD_A_FILT_CNT = 8'h08;
  localparam logic [7:0] CGD_A_SH_CNT = 8'h0C;
  localparam logic [7:0] CGD_A_FILT0 = 8'h10;
  localparam logic [7:0] CGD_A_FILT3 = 8'h1C;
  localparam logic [7:0] CGD_A_SH_SEL = 8'h30;
  localparam logic [7:0] CGD_A_SH_PGN = 8'h34;
  localparam logic [7:0] CGD_A_SH_INFO = 8'h38;
  // ctrl bit 0: clear special-handling list; status field positions
  localparam int CGD_CTRL_CLR_BIT = 0;
  localparam int CGD_ST_ECHO_BIT = 3;
  localparam int CGD_ST_IFACE_BIT = 4;
  localparam int CGD_ST_SHFULL_BIT = 5;
  localparam int CGD_ST_BADOP_BIT = 6;

  // one special-handling entry, multi-byte fields held lsb first
  typedef struct packed {
    logic [31:0] pgn;
    logic [15:0] txint;
    logic [15:0] flags;
  } cgd_sh_entry_t;

  // one byte on the serial link with its valid
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cgd_byte_t;

  typedef enum logic [2:0] {
    CGD_S_IDLE = 3'b001,
    CGD_S_PARAM = 3'b010,
    CGD_S_REPLY = 3'b100
  } cgd_state_t;
endpackage

/* File: src/cgd_decoder.sv */
// gateway configuration command decoder with apb register access
// Behaviour
// RQ1 - opcode 0x09 without parameters returns the held acceptance filters.
// RQ2 - opcode 0x05 takes one rate byte choosing 50k,100k,125k,250k,500k or 1M by index 0 to 5.
// RQ3 - opcode 0x06 takes one state byte, 0 switches transmit echo off and 1 on.
// RQ4 - opcode 0x0B without parameters reports the bit-rate index in use.
// RQ5 - opcode 0x07 adds a pgn entry from four pgn, two interval and two flag bytes.
// RQ6 - entry flag 0x01 allows multi-packet transport, flag 0x02 tags frames with the link id.
// RQ7 - multi-byte parameters arrive least significant byte first.
`timescale 1ns/1ps
module cgd_decoder
  import cgd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cgd_byte_t rx_byte,
  output logic rx_ready,
  output cgd_byte_t tx_byte,
  input wire logic tx_ready,
  output logic [2:0] bit_rate_selector,
  output logic tx_echo_en,
  output logic iface_mode,
  input wire logic [31:0] query_pgn,
  output logic query_hit,
  output logic query_tp_allow,
  output logic query_wireless_link_tag
);
  cgd_state_t state_r;
  logic [7:0] op_r;
  logic [3:0] pcnt_r;
  logic [63:0] param_r;
  logic [4:0] ridx_r;
  logic [4:0] rlen;
  logic [2:0] rate_r;
  logic echo_r;
  logic iface_r;
  logic badop_r;
  logic shfull_r;
  logic [31:0] filt_r [CGD_NFILT];
  logic [2:0] filt_cnt_r;
  cgd_sh_entry_t sh_r [CGD_NSH];
  logic [2:0] sh_cnt_r;
  logic [1:0] sh_sel_r;
  logic rx_fire;
  logic tx_fire;
  logic cmd_done;
  logic apb_wr;
  logic apb_setup;
  logic unmapped;
  logic [7:0] rbyte;
  logic [4:0] fofs;
  cgd_sh_entry_t new_ent;
  logic sh_found;

  assign rx_fire = rx_byte.valid & rx_ready;
  assign tx_fire = tx_byte.valid & tx_ready;
  assign rx_ready = (state_r != CGD_S_REPLY);
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign bit_rate_selector = rate_r;
  assign tx_echo_en = echo_r;
  assign iface_mode = iface_r;
  // last parameter byte of a pending command has just arrived
  assign cmd_done = (state_r == CGD_S_PARAM) & rx_fire & (pcnt_r == CGD_LEN_ONE);
  // the eight bytes fill each field lsb first: pgn b0..b3, interval b4..b5, then flags b6..b7
  assign new_ent = {param_r[39:8], param_r[55:40], rx_byte.data, param_r[63:56]}; // RQ7 RQ5

  // reply length: opcode echo, then payload
  assign rlen = (op_r == CGD_OP_GET_FILT) ? 5'(5'd2 + {filt_cnt_r, 2'b00}) : 5'd2; // RQ1 RQ4

  // a matching pgn among the live entries is updated in place, not appended
  always_comb begin
    sh_found = 1'b0;
    for (int i = 0; i < CGD_NSH; i++) begin
      sh_found = sh_found | (3'(i) < sh_cnt_r && sh_r[i].pgn == new_ent.pgn);
    end
  end

  // byte to send at reply index, filter words go out lsb first
  always_comb begin
    fofs = 5'(ridx_r - 5'd2);
    if (ridx_r == 5'd0) begin
      rbyte = op_r;
    end else if (ridx_r == 5'd1) begin
      if (op_r == CGD_OP_GET_FILT) begin
        rbyte = {5'h00, filt_cnt_r}; // RQ1
      end else begin
        rbyte = {5'h00, rate_r}; // RQ4
      end
    end else begin
      rbyte = filt_r[fofs[3:2]][8*fofs[1:0] +: 8]; // RQ1 RQ7
    end
  end

  // command sequencing: opcode, parameter bytes, optional reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CGD_S_IDLE;
      op_r <= 8'h00;
      pcnt_r <= 4'h0;
      param_r <= 64'h0;
      ridx_r <= 5'h00;
      tx_byte <= '0;
      badop_r <= 1'b0;
    end else begin
      if (apb_wr && paddr == CGD_A_STATUS && pwdata[CGD_ST_BADOP_BIT]) begin
        badop_r <= 1'b0; // cleared ahead of the decode, so a bad opcode in the same cycle wins
      end
      case (state_r)
        CGD_S_IDLE: begin
          if (rx_fire) begin
            op_r <= rx_byte.data;
            ridx_r <= 5'h00;
            if (rx_byte.data == CGD_OP_RATE || rx_byte.data == CGD_OP_ECHO) begin
              pcnt_r <= CGD_LEN_ONE;
              state_r <= CGD_S_PARAM;
            end else if (rx_byte.data == CGD_OP_SH_ADD) begin
              pcnt_r <= CGD_LEN_SH;
              state_r <= CGD_S_PARAM;
            end else if (rx_byte.data == CGD_OP_GET_FILT ||
                         rx_byte.data == CGD_OP_GET_RATE) begin
              // no parameters follow a query, so reply at once
              tx_byte <= '{valid: 1'b1, data: rx_byte.data}; // RQ1 RQ4
              state_r <= CGD_S_REPLY;
            end else if (rx_byte.data != CGD_OP_IFACE) begin
              badop_r <= 1'b1; // unhandled opcode dropped, sticky flag for software
            end
          end
        end
        CGD_S_PARAM: begin
          if (rx_fire) begin
            param_r <= {rx_byte.data, param_r[63:8]};
            pcnt_r <= 4'(pcnt_r - 4'h1);
            if (pcnt_r == CGD_LEN_ONE) begin
              state_r <= CGD_S_IDLE;
            end
          end
        end
        CGD_S_REPLY: begin
          if (tx_fire) begin
            // valid drops for one cycle so a byte is never offered before it is loaded
            tx_byte.valid <= 1'b0;
            if (5'(ridx_r + 5'd1) == rlen) begin
              state_r <= CGD_S_IDLE;
            end else begin
              ridx_r <= 5'(ridx_r + 5'd1);
            end
          end else if (!tx_byte.valid) begin
            tx_byte <= '{valid: 1'b1, data: rbyte}; // RQ1 RQ4
          end
        end
        default: state_r <= CGD_S_IDLE;
      endcase
    end
  end

  // bit rate, echo and interface mode settings; out-of-range values are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r <= CGD_RATE_RST;
      echo_r <= 1'b0;
      iface_r <= 1'b0;
    end else begin
      if (cmd_done && op_r == CGD_OP_RATE && rx_byte.data <= {5'h00, CGD_RATE_MAX}) begin
        rate_r <= rx_byte.data[2:0]; // RQ2
      end
      if (cmd_done && op_r == CGD_OP_ECHO && rx_byte.data <= CGD_ECHO_ON) begin
        echo_r <= rx_byte.data[0]; // RQ3
      end
      if (state_r == CGD_S_IDLE && rx_fire && rx_byte.data == CGD_OP_IFACE) begin
        iface_r <= 1'b1;
      end
    end
  end

  // special-handling list: an existing pgn is updated, a new one appended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_cnt_r <= 3'h0;
      shfull_r <= 1'b0;
      for (int i = 0; i < CGD_NSH; i++) begin
        sh_r[i] <= '0;
      end
    end else begin
      if (apb_wr && paddr == CGD_A_CTRL && pwdata[CGD_CTRL_CLR_BIT]) begin
        sh_cnt_r <= 3'h0;
        shfull_r <= 1'b0;
      end
      // placed after the clear so an append of a new pgn in the same cycle is kept
      if (cmd_done && op_r == CGD_OP_SH_ADD) begin
        for (int i = 0; i < CGD_NSH; i++) begin
          if (3'(i) < sh_cnt_r && sh_r[i].pgn == new_ent.pgn) begin
            sh_r[i] <= new_ent; // RQ5
          end
        end
        if (!sh_found && sh_cnt_r < CGD_NSH_MAX) begin
          sh_r[sh_cnt_r[1:0]] <= new_ent; // RQ5
          sh_cnt_r <= 3'(sh_cnt_r + 3'h1);
        end else if (!sh_found) begin
          shfull_r <= 1'b1; // list full, entry dropped
        end
      end
    end
  end

  // pgn lookup for the frame path, one cycle of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      query_hit <= 1'b0;
      query_tp_allow <= 1'b0;
      query_wireless_link_tag <= 1'b0;
    end else begin
      query_hit <= 1'b0;
      query_tp_allow <= 1'b0;
      query_wireless_link_tag <= 1'b0;
      for (int i = 0; i < CGD_NSH; i++) begin
        if (3'(i) < sh_cnt_r && sh_r[i].pgn == query_pgn) begin
          query_hit <= 1'b1;
          query_tp_allow <= sh_r[i].flags[CGD_FLAG_TP_BIT]; // RQ6
          query_wireless_link_tag <= sh_r[i].flags[CGD_FLAG_TAG_BIT]; // RQ6
        end
      end
    end
  end

  // software-held acceptance filters and list selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt_r <= 3'h0;
      sh_sel_r <= 2'h0;
      for (int i = 0; i < CGD_NFILT; i++) begin
        filt_r[i] <= 32'h00000000;
      end
    end else if (apb_wr) begin
      if (paddr == CGD_A_FILT_CNT) begin
        // counts 5 to 7 in pwdata[2:0] saturate at the table size; higher bits of pwdata are dropped
        filt_cnt_r <= (pwdata[2:0] > CGD_NFILT_MAX) ? CGD_NFILT_MAX : pwdata[2:0];
      end else if (paddr == CGD_A_SH_SEL) begin
        sh_sel_r <= pwdata[1:0];
      end else if (paddr >= CGD_A_FILT0 && paddr <= CGD_A_FILT3 && paddr[1:0] == 2'b00) begin
        filt_r[paddr[3:2]] <= pwdata;
      end
    end
  end

  // unmapped or misaligned offsets answer with pslverr
  always_comb begin
    unmapped = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      unmapped = 1'b1;
    end else if (paddr == CGD_A_CTRL || paddr == CGD_A_STATUS || paddr == CGD_A_FILT_CNT) begin
      unmapped = 1'b0;
    end else if (paddr == CGD_A_SH_CNT || paddr == CGD_A_SH_SEL) begin
      unmapped = 1'b0;
    end else if (paddr == CGD_A_SH_PGN || paddr == CGD_A_SH_INFO) begin
      unmapped = 1'b0;
    end else if (paddr >= CGD_A_FILT0 && paddr <= CGD_A_FILT3) begin
      unmapped = 1'b0;
    end else begin
      unmapped = 1'b1;
    end
  end
  assign pslverr = psel & penable & unmapped;

  // read data captured in the setup cycle so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      if (paddr == CGD_A_STATUS) begin
        prdata <= {25'h0, badop_r, shfull_r, iface_r, echo_r, rate_r};
      end else if (paddr == CGD_A_FILT_CNT) begin
        prdata <= {29'h0, filt_cnt_r};
      end else if (paddr == CGD_A_SH_CNT) begin
        prdata <= {29'h0, sh_cnt_r};
      end else if (paddr == CGD_A_SH_SEL) begin
        prdata <= {30'h0, sh_sel_r};
      end else if (paddr == CGD_A_SH_PGN) begin
        prdata <= sh_r[sh_sel_r].pgn;
      end else if (paddr == CGD_A_SH_INFO) begin
        prdata <= {sh_r[sh_sel_r].flags, sh_r[sh_sel_r].txint};
      end else if (paddr >= CGD_A_FILT0 && paddr <= CGD_A_FILT3 && paddr[1:0] == 2'b00) begin
        prdata <= filt_r[paddr[3:2]];
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule

/* File: test/cgd_decoder_properties.sv */
// port-level checks of the configuration command decoder
`timescale 1ns/1ps
module cgd_decoder_properties
  import cgd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire cgd_byte_t rx_byte,
  input wire logic rx_ready,
  input wire cgd_byte_t tx_byte,
  input wire logic tx_ready,
  input wire logic [2:0] bit_rate_selector,
  input wire logic tx_echo_en,
  input wire logic iface_mode
);
  logic acc;
  logic [3:0] pend_r;
  logic [7:0] op_r;
  assign acc = rx_byte.valid && rx_ready;
  // count parameters still due, so a parameter byte never passes for an opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 4'h0;
      op_r <= 8'h00;
    end else if (acc && pend_r != 4'h0) begin
      pend_r <= pend_r - 4'h1;
    end else if (acc) begin
      op_r <= rx_byte.data;
      pend_r <= (rx_byte.data == CGD_OP_SH_ADD) ? CGD_LEN_SH :
        (rx_byte.data == CGD_OP_RATE || rx_byte.data == CGD_OP_ECHO) ? CGD_LEN_ONE : 4'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_par(logic [7:0] op);
    acc && pend_r == 4'h1 && op_r == op;
  endsequence
  sequence s_op(logic [7:0] op);
    acc && pend_r == 4'h0 && rx_byte.data == op;
  endsequence
  sequence s_reply(logic [7:0] op);
    tx_byte.valid && tx_byte.data == op;
  endsequence
  property p_rate_set;
    s_par(CGD_OP_RATE) ##0 rx_byte.data <= 8'h05 |=> bit_rate_selector == $past(rx_byte.data[2:0]);
  endproperty
  property p_rate_keep;
    !(acc && pend_r == 4'h1 && op_r == CGD_OP_RATE) |=> $stable(bit_rate_selector);
  endproperty
  property p_rate_max;
    bit_rate_selector <= CGD_RATE_MAX;
  endproperty
  property p_echo_set;
    s_par(CGD_OP_ECHO) ##0 rx_byte.data <= 8'h01 |=> tx_echo_en == $past(rx_byte.data[0]);
  endproperty
  property p_iface;
    s_op(CGD_OP_IFACE) |=> iface_mode;
  endproperty
  property p_get_rate;
    s_op(CGD_OP_GET_RATE) |=> s_reply(CGD_OP_GET_RATE);
  endproperty
  property p_get_filt;
    s_op(CGD_OP_GET_FILT) |=> s_reply(CGD_OP_GET_FILT);
  endproperty
  property p_tx_hold;
    tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data);
  endproperty
  property p_pready;
    psel && penable |-> pready;
  endproperty
  a_rate_set: assert property (p_rate_set) else $error("rate not taken");
  a_rate_keep: assert property (p_rate_keep) else $error("rate moved");
  a_rate_max: assert property (p_rate_max) else $error("rate out of range");
  a_echo_set: assert property (p_echo_set) else $error("echo not taken");
  a_iface: assert property (p_iface) else $error("interface mode not set");
  a_get_rate: assert property (p_get_rate) else $error("no rate reply");
  a_get_filt: assert property (p_get_filt) else $error("no filter reply");
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
  a_pready: assert property (p_pready) else $error("no pready");
endmodule
bind cgd_decoder cgd_decoder_properties chk_u (.pclk, .presetn, .psel, .penable, .pready,
  .rx_byte, .rx_ready, .tx_byte, .tx_ready, .bit_rate_selector, .tx_echo_en, .iface_mode);

/* File: test/cgd_host_model.sv */
// host end of the wireless serial link: sends commands, takes replies
`timescale 1ns/1ps
module cgd_host_model
  import cgd_pkg::*;
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic rx_ready,
  input wire cgd_byte_t tx_byte,
  output cgd_byte_t rx_byte,
  output logic tx_ready
);
  initial rx_byte = '{1'b0, 8'hA5};
  initial tx_ready = 1'b0;
  // a slow host takes a reply byte only every other cycle
  always @(posedge pclk) tx_ready <= slow ? !tx_ready : 1'b1;
  // opcode then its fixed parameters, low byte first, each held until taken
  task automatic send(input logic [7:0] b [$]);
    foreach (b[i]) begin
      rx_byte <= '{1'b1, b[i]};
      // held until the edge at which rx_ready is seen high
      do @(posedge pclk); while (rx_ready !== 1'b1);
    end
    // released line shows the inverse so a stale byte cannot look valid data
    rx_byte <= '{1'b0, ~b[b.size()-1]};
  endtask
  // reply bytes are counted only at a handshake
  task automatic get(input int n, output logic [7:0] q [$]);
    q = {};
    repeat (n) begin
      do @(posedge pclk); while (!(tx_byte.valid === 1'b1 && tx_ready === 1'b1));
      q.push_back(tx_byte.data);
    end
  endtask
endmodule

/* File: test/can_gateway_config_cmd_decoder_bench.sv */
// self-checking bench for the configuration command decoder
`timescale 1ns/1ps
module can_gateway_config_cmd_decoder_bench
  import cgd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] query_pgn = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rx_ready, tx_ready, tx_echo_en, iface_mode, er;
  logic query_hit, query_tp_allow, query_wireless_link_tag;
  logic [2:0] bit_rate_selector;
  cgd_byte_t rx_byte, tx_byte;
  logic [7:0] q [$];
  int err_count = 0;
  int check_count = 0;
  always #4 pclk = ~pclk;
  cgd_decoder dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_byte, .rx_ready, .tx_byte, .tx_ready, .bit_rate_selector,
    .tx_echo_en, .iface_mode, .query_pgn, .query_hit, .query_tp_allow,
    .query_wireless_link_tag);
  cgd_host_model host_u (.pclk, .slow, .rx_ready, .tx_byte, .rx_byte, .tx_ready);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; answer taken at the edge where pready is seen, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // every rate index, each read back; odd passes stall the reply
  task automatic t_rate();
    for (int i = 0; i <= 5; i++) begin
      slow <= i[0];
      host_u.send('{CGD_OP_RATE, 8'(i), CGD_OP_GET_RATE});
      host_u.get(2, q);
      chk(bit_rate_selector, i, "rate");
      chk({q[0], q[1]}, {CGD_OP_GET_RATE, 8'(i)}, "get rate");
    end
    host_u.send('{CGD_OP_RATE, 8'h06});
    @(negedge pclk);
    chk(bit_rate_selector, 32'h5, "rate ignored");
    @(posedge pclk);
    $display("test rate done");
  endtask
  task automatic t_echo();
    host_u.send('{CGD_OP_ECHO, 8'h01, CGD_OP_IFACE});
    @(negedge pclk);
    chk(tx_echo_en, 1'b1, "echo on");
    chk(iface_mode, 1'b1, "iface");
    @(posedge pclk);
    // 3 has bit 0 set but is out of range, so echo must stay off
    host_u.send('{CGD_OP_ECHO, 8'h00, CGD_OP_ECHO, 8'h03});
    @(negedge pclk);
    chk(tx_echo_en, 1'b0, "echo off");
    @(posedge pclk);
    // an opcode outside the set is dropped and flagged for software
    host_u.send('{8'h0C});
    apb(1'b0, CGD_A_STATUS, 32'h0);
    chk(rd, 32'h0000_0055, "status bad opcode");
    apb(1'b1, CGD_A_STATUS, 32'h0000_0040);
    apb(1'b0, CGD_A_STATUS, 32'h0);
    chk(rd, 32'h0000_0015, "status cleared");
    $display("test echo done");
  endtask
  task automatic t_filt();
    logic [7:0] e [10] = '{8'h09, 8'h02, 8'h78, 8'h56, 8'h34, 8'h12, 8'h42, 8'h00, 8'hFE, 8'hCA};
    apb(1'b1, CGD_A_FILT0, 32'h1234_5678);
    apb(1'b1, CGD_A_FILT0 + 8'h04, 32'hCAFE_0042);
    apb(1'b1, CGD_A_FILT_CNT, 32'h2);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1, "unmapped");
    chk(rd, 32'h0, "unmapped data");
    host_u.send('{CGD_OP_GET_FILT});
    host_u.get(10, q);
    for (int i = 0; i < 10; i++) chk(q[i], e[i], "filter reply");
    $display("test filters done");
  endtask
  task automatic t_sh();
    logic [31:0] pg [3] = '{32'h0001_FEEF, 32'h0000_EB00, 32'h0000_EB01};
    logic [2:0] ex [3] = '{3'b111, 3'b101, 3'b000};
    // two entries back to back, multi-byte fields low byte first
    host_u.send('{CGD_OP_SH_ADD, 8'hEF, 8'hFE, 8'h01, 8'h00, 8'h34, 8'h12, 8'h03, 8'h00,
      CGD_OP_SH_ADD, 8'h00, 8'hEB, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h02, 8'h00});
    apb(1'b0, CGD_A_SH_CNT, 32'h0);
    chk(rd, 32'h2, "entries");
    apb(1'b1, CGD_A_SH_SEL, 32'h0);
    apb(1'b0, CGD_A_SH_INFO, 32'h0);
    chk(rd, 32'h0003_1234, "entry info");
    for (int i = 0; i < 3; i++) begin
      query_pgn <= pg[i];
      @(posedge pclk);
      @(negedge pclk);
      chk({query_hit, query_tp_allow, query_wireless_link_tag}, ex[i], "query");
      @(posedge pclk);
    end
    apb(1'b1, CGD_A_CTRL, 32'h1);
    apb(1'b0, CGD_A_SH_CNT, 32'h0);
    chk(rd, 32'h0, "list cleared");
    $display("test special list done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(bit_rate_selector, CGD_RATE_RST, "reset rate");
    chk(tx_echo_en, 1'b0, "reset echo");
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_rate();
    t_echo();
    t_filt();
    t_sh();
    end_of_test();
  end
  // whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule
